// *** inc/adcrc_pkg.sv ***
// package: constants and types for the converter control block
package adcrc_pkg;
    localparam int          CHAN_COUNT     = 8;
    localparam int          CHAN_BITS      = 3;
    localparam int          RESULT_BITS    = 10;
    localparam int          PRESCALE_BITS  = 4;
    localparam int          SAMPLE_PERIODS = 14;
    localparam logic        POWER_UP_RESET = 1'b0;
    localparam logic        IRQ_EN_RESET   = 1'b0;
    localparam logic [3:0]  PRESCALE_RESET = 4'h0;
    localparam logic [2:0]  CHAN_RESET     = 3'h0;
    localparam logic [9:0]  RESULT_RESET   = 10'h000;
    localparam logic [9:0]  SAR_RESET      = 10'h000;
    typedef enum logic [1:0] {ADCRC_IDLE, ADCRC_SAMPLE, ADCRC_CONVERT} adcrc_state_t;
endpackage

// *** rtl/adcrc_clock_divider.sv ***
// prescaler that issues one-cycle conversion clock ticks
`timescale 1ns/1ns
module adcrc_clock_divider
    import adcrc_pkg::*;
#(
    parameter int PRESCALE_W = PRESCALE_BITS
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  run,
    input  wire logic [PRESCALE_W-1:0] rate,
    output logic                       tick
);
    logic [PRESCALE_W:0] count;
    logic [PRESCALE_W:0] next_count;
    logic                next_tick;
    logic [PRESCALE_W:0] limit;

    // factor is (rate + 1) * 2 bus clocks
    always_comb
    begin
        limit      = {rate, 1'b1};
        next_count = count;
        next_tick  = 1'b0;
        if (!run)
        begin
            next_count = '0;
        end
        else if (count >= limit)
        begin
            next_count = '0;
            next_tick  = 1'b1;
        end
        else
        begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule

// *** rtl/adcrc_control.sv ***
// converter control: power-up, start and abort, sar sequence, complete flag and irq
`timescale 1ns/1ns
//
// Contract
// RQ1: system reset returns block to initial state
// RQ2: reset reloads registers, leaves converter powered down
// RQ3: power-up bit resets to zero
// RQ4: reset stops conversion, clears flag and sar
// RQ5: reset withdraws pending interrupt request
// RQ6: power-up does not reinitialise registers
// RQ7: control write aborts conversion, keeps registers
// RQ8: irq at conversion end with result loaded
// RQ9: without irq enable software polls flag
// RQ10: irq stays while complete flag set
// RQ11: status-control write clears complete flag
// RQ12: result high or low read clears flag
// RQ13: mux routes one of eight channels
// RQ14: sampling lasts fourteen conversion clock periods
// RQ15: status-control write restarts a conversion
// RQ16: pin-enable write aborts without restarting
// RQ17: power-down stops clock and aborts conversion
// RQ18: result load and flag set same cycle
module adcrc_control
    import adcrc_pkg::*;
#(
    parameter int NUM_CHAN   = CHAN_COUNT,
    parameter int RES_W      = RESULT_BITS,
    parameter int PRESCALE_W = PRESCALE_BITS,
    parameter int SAMPLE_LEN = SAMPLE_PERIODS
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  controlWrite,
    input  wire logic                  converterPowerUpIn,
    input  wire logic [PRESCALE_W-1:0] prescaleIn,
    input  wire logic                  statusControlWrite,
    input  wire logic                  conversionIrqEnableIn,
    input  wire logic [CHAN_BITS-1:0]  channelIn,
    input  wire logic                  pinEnableWrite,
    input  wire logic                  resultHighRead,
    input  wire logic                  resultLowRead,
    input  wire logic                  compareHigh,
    output logic                       converterPowerUp,
    output logic                       conversionIrqEnable,
    output logic [PRESCALE_W-1:0]      prescale,
    output logic [CHAN_BITS-1:0]       channel,
    output logic [NUM_CHAN-1:0]        channelSelect,
    output logic                       sampleActive,
    output logic [RES_W-1:0]           sarValue,
    output logic [RES_W-1:0]           result,
    output logic                       conversion_complete_flag,
    output logic                       converterIrq,
    output logic                       busy
);
    import adcrc_pkg::*;

    localparam int SCNT_W = $clog2(SAMPLE_LEN + 1);
    localparam int BCNT_W = $clog2(RES_W + 1);

    adcrc_state_t              state;
    adcrc_state_t              next_state;
    logic [SCNT_W-1:0]         sampleCount;
    logic [SCNT_W-1:0]         next_sampleCount;
    logic [BCNT_W-1:0]         bitIndex;
    logic [BCNT_W-1:0]         next_bitIndex;
    logic [RES_W-1:0]          next_sarValue;
    logic [RES_W-1:0]          next_result;
    logic                      next_flag;
    logic                      next_irq;
    logic                      next_powerUp;
    logic                      next_irqEnable;
    logic [PRESCALE_W-1:0]     next_prescale;
    logic [CHAN_BITS-1:0]      next_channel;
    logic [NUM_CHAN-1:0]       next_channelSelect;
    logic                      next_sampleActive;
    logic                      next_busy;
    logic                      convTick;
    logic                      abort;
    logic                      done;
    logic [RES_W-1:0]          trialBits;

    // conversion clock only runs while powered up
    adcrc_clock_divider #(
        .PRESCALE_W (PRESCALE_W)
    ) u_divider (
        .sys_clk (sys_clk),
        .rst     (rst),
        .run     (converterPowerUp),                                 // [RQ17]
        .rate    (prescale),
        .tick    (convTick)
    );

    // software-visible settings; writes only store values
    always_comb
    begin
        next_powerUp   = converterPowerUp;
        next_prescale  = prescale;
        next_irqEnable = conversionIrqEnable;
        next_channel   = channel;
        if (controlWrite)
        begin
            next_powerUp  = converterPowerUpIn;                      // [RQ6]
            next_prescale = prescaleIn;
        end
        if (statusControlWrite)
        begin
            next_irqEnable = conversionIrqEnableIn;
            next_channel   = channelIn;
        end
    end

    // sequencer: sample then successive approximation
    always_comb
    begin
        abort              = controlWrite || pinEnableWrite || !converterPowerUp; // [RQ7] [RQ16] [RQ17]
        done               = 1'b0;
        trialBits          = '0;
        next_state         = state;
        next_sampleCount   = sampleCount;
        next_bitIndex      = bitIndex;
        next_sarValue      = sarValue;
        next_result        = result;
        if (statusControlWrite && converterPowerUp && !controlWrite)
        begin
            next_state       = ADCRC_SAMPLE;                         // [RQ15]
            next_sampleCount = '0;
            next_sarValue    = '0;
        end
        else if (abort)
        begin
            next_state = ADCRC_IDLE;
        end
        else if (convTick)
        begin
            unique case (state)
                ADCRC_IDLE:
                begin
                    next_state = ADCRC_IDLE;
                end
                ADCRC_SAMPLE:
                begin
                    if (sampleCount == SCNT_W'(SAMPLE_LEN - 1))      // [RQ14]
                    begin
                        next_state    = ADCRC_CONVERT;
                        next_bitIndex = BCNT_W'(RES_W - 1);
                        next_sarValue = '0;
                    end
                    else
                    begin
                        next_sampleCount = sampleCount + 1'b1;
                    end
                end
                ADCRC_CONVERT:
                begin
                    // keep trial bit when the input is at or above the trial level
                    trialBits = sarValue;
                    trialBits[bitIndex] = compareHigh;
                    next_sarValue = trialBits;
                    if (bitIndex == '0)
                    begin
                        next_state  = ADCRC_IDLE;
                        next_result = trialBits;                     // [RQ18]
                        done        = 1'b1;
                    end
                    else
                    begin
                        next_sarValue[bitIndex - 1'b1] = 1'b1;
                        next_bitIndex = bitIndex - 1'b1;
                    end
                end
            endcase
        end
        if (next_state == ADCRC_CONVERT && state == ADCRC_SAMPLE)
        begin
            next_sarValue[RES_W-1] = 1'b1;
        end
    end

    // complete flag: completion wins over a same-cycle clear
    always_comb
    begin
        next_flag = conversion_complete_flag;
        if (statusControlWrite || resultHighRead || resultLowRead)
        begin
            next_flag = 1'b0;                                        // [RQ11] [RQ12]
        end
        if (done)
        begin
            next_flag = 1'b1;                                        // [RQ18]
        end
        next_irq           = next_flag && next_irqEnable;            // [RQ8] [RQ10]
        next_busy          = (next_state != ADCRC_IDLE);
        next_sampleActive  = (next_state == ADCRC_SAMPLE);
        next_channelSelect = '0;
        if (next_state == ADCRC_SAMPLE)
        begin
            next_channelSelect[next_channel] = 1'b1;                 // [RQ13]
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            converterPowerUp         <= POWER_UP_RESET;              // [RQ2] [RQ3]
            prescale                 <= PRESCALE_RESET;
            conversionIrqEnable      <= IRQ_EN_RESET;
            channel                  <= CHAN_RESET;
            state                    <= ADCRC_IDLE;                  // [RQ1] [RQ4]
            sampleCount              <= '0;
            bitIndex                 <= '0;
            sarValue                 <= SAR_RESET;                   // [RQ4]
            result                   <= RESULT_RESET;
            conversion_complete_flag <= 1'b0;                        // [RQ4]
            converterIrq             <= 1'b0;                        // [RQ5]
            busy                     <= 1'b0;
            sampleActive             <= 1'b0;
            channelSelect            <= '0;
        end
        else
        begin
            converterPowerUp         <= next_powerUp;
            prescale                 <= next_prescale;
            conversionIrqEnable      <= next_irqEnable;
            channel                  <= next_channel;
            state                    <= next_state;
            sampleCount              <= next_sampleCount;
            bitIndex                 <= next_bitIndex;
            sarValue                 <= next_sarValue;
            result                   <= next_result;
            conversion_complete_flag <= next_flag;
            converterIrq             <= next_irq;
            busy                     <= next_busy;
            sampleActive             <= next_sampleActive;
            channelSelect            <= next_channelSelect;
        end
    end
endmodule

// *** tb/adcrc_checker.sv ***
// checker: port properties of the converter control block
`timescale 1ns/1ns
module adcrc_checker
#(
    parameter int NUM_CHAN = 8,
    parameter int RES_W    = 10
)
(
    input wire logic                sys_clk,
    input wire logic                rst,
    input wire logic                controlWrite,
    input wire logic                statusControlWrite,
    input wire logic                pinEnableWrite,
    input wire logic                converterPowerUp,
    input wire logic                conversionIrqEnable,
    input wire logic [NUM_CHAN-1:0] channelSelect,
    input wire logic                sampleActive,
    input wire logic [RES_W-1:0]    sarValue,
    input wire logic [RES_W-1:0]    result,
    input wire logic                conversion_complete_flag,
    input wire logic                converterIrq,
    input wire logic                busy
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    reset_clear_a: assert property (disable iff (1'b0) rst |->
        !busy && !converterPowerUp && !conversion_complete_flag && !converterIrq && sarValue == 0)
        else $error("state not cleared in reset");
    irq_follows_a: assert property (converterIrq == (conversion_complete_flag && conversionIrqEnable))
        else $error("irq differs from flag and enable");
    result_load_a: assert property ($changed(result) |-> $fell(busy) && conversion_complete_flag)
        else $error("result loaded without completion");
    flag_write_a: assert property (statusControlWrite && !busy |=> !conversion_complete_flag)
        else $error("flag kept after status write");
    ctrl_abort_a: assert property (controlWrite |=> !busy)
        else $error("control write did not abort");
    pin_abort_a: assert property (pinEnableWrite && !statusControlWrite |=> !busy)
        else $error("pin enable write did not abort");
    power_down_a: assert property (!converterPowerUp |=> !busy)
        else $error("busy while powered down");
    start_conv_a: assert property (statusControlWrite && converterPowerUp && !controlWrite && !pinEnableWrite
        |=> busy && sampleActive && $onehot(channelSelect)) else $error("conversion did not start");
endmodule

bind adcrc_control adcrc_checker #(.NUM_CHAN(NUM_CHAN), .RES_W(RES_W)) i_adcrc_checker (
    .sys_clk(sys_clk), .rst(rst), .controlWrite(controlWrite), .statusControlWrite(statusControlWrite),
    .pinEnableWrite(pinEnableWrite), .converterPowerUp(converterPowerUp),
    .conversionIrqEnable(conversionIrqEnable), .channelSelect(channelSelect), .sampleActive(sampleActive),
    .sarValue(sarValue), .result(result), .conversion_complete_flag(conversion_complete_flag),
    .converterIrq(converterIrq), .busy(busy));

// *** tb/adcrc_analog_model.sv ***
// analog source model: eight channel levels and the comparator
`timescale 1ns/1ns
module adcrc_analog_model
(
    input  wire logic [adcrc_pkg::CHAN_COUNT-1:0]  channelSelect,
    input  wire logic                              sys_clk,
    input  wire logic [adcrc_pkg::RESULT_BITS-1:0] sarValue,
    output logic                                   compareHigh
);
    import adcrc_pkg::*;
    logic [CHAN_BITS-1:0] heldChan = 3'h0;
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < CHAN_COUNT; i++)
            if (channelSelect[i])
                heldChan <= CHAN_BITS'(i);
    end
    // level of the sampled channel against the trial value
    assign compareHigh = (10'h0A5 + 10'(heldChan) * 10'h051) >= sarValue;
endmodule

// *** tb/adc_reset_and_irq_control_test.sv ***
// testbench for the converter control block
`timescale 1ns/1ns
module adc_reset_and_irq_control_test;
    import adcrc_pkg::*;
    logic       sys_clk, rst, controlWrite, converterPowerUpIn, statusControlWrite, conversionIrqEnableIn;
    logic       pinEnableWrite, resultHighRead, resultLowRead, compareHigh, converterPowerUp;
    logic       conversionIrqEnable, sampleActive, conversion_complete_flag, converterIrq, busy;
    logic [3:0] prescaleIn, prescale;
    logic [2:0] channelIn, channel;
    logic [7:0] channelSelect;
    logic [9:0] sarValue, result;
    int         err_total = 0;
    int         n_compared = 0;
    adcrc_control i_adcrc_control (.sys_clk(sys_clk), .rst(rst), .controlWrite(controlWrite),
        .converterPowerUpIn(converterPowerUpIn), .prescaleIn(prescaleIn), .statusControlWrite(statusControlWrite),
        .conversionIrqEnableIn(conversionIrqEnableIn), .channelIn(channelIn), .pinEnableWrite(pinEnableWrite),
        .resultHighRead(resultHighRead), .resultLowRead(resultLowRead), .compareHigh(compareHigh),
        .converterPowerUp(converterPowerUp), .conversionIrqEnable(conversionIrqEnable), .prescale(prescale),
        .channel(channel), .channelSelect(channelSelect), .sampleActive(sampleActive), .sarValue(sarValue),
        .result(result), .conversion_complete_flag(conversion_complete_flag), .converterIrq(converterIrq),
        .busy(busy));
    adcrc_analog_model i_adcrc_analog_model (.channelSelect(channelSelect), .sys_clk(sys_clk),
        .sarValue(sarValue), .compareHigh(compareHigh));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // k: 0 control, 1 status, 2 pin enable, 3 high read, 4 low read
    task automatic strobe(input int k, input logic d, input logic [3:0] v);
        @(posedge sys_clk);
        {resultLowRead, resultHighRead, pinEnableWrite, statusControlWrite, controlWrite} <= 5'(1 << k);
        converterPowerUpIn <= d;
        conversionIrqEnableIn <= d;
        prescaleIn <= v;
        channelIn <= v[2:0];
        @(posedge sys_clk);
        {resultLowRead, resultHighRead, pinEnableWrite, statusControlWrite, controlWrite} <= 5'h00;
        @(negedge sys_clk);
    endtask
    task automatic span(ref logic s, input logic lvl, output int n);
        n = 0;
        while (s === lvl && n < 999)
        begin
            n++;
            @(negedge sys_clk);
        end
    endtask
    task automatic conv(input logic ie, input logic [2:0] ch, input logic [3:0] ps, input logic restart);
        int n;
        int f;
        f = (ps + 1) * 2;
        if (restart)
            check(busy, 1'b1);
        else
            strobe(0, 1'b1, ps);
        strobe(1, ie, {1'b0, ch});
        span(sampleActive, 1'b1, n);
        check(16'(n > 13 * f && n <= 14 * f + 1), 16'h0001);
        span(conversion_complete_flag, 1'b0, n);
        check({busy, converterIrq, 4'h0, result}, {1'b0, ie, 4'h0, 10'h0A5 + 10'(ch) * 10'h051});
        $display("conversion done on channel %0d", ch);
    endtask
    task automatic abort(input int k, input logic pu);
        strobe(0, 1'b1, 4'h0);
        strobe(1, 1'b1, 4'h5);
        repeat (40) @(negedge sys_clk);
        strobe(k, pu, 4'h0);
        check(busy, 1'b0);
        repeat (60) @(negedge sys_clk);
        strobe(0, 1'b1, 4'h0);
        check({conversion_complete_flag, busy, conversionIrqEnable, channel, result}, 16'h36DC);
        $display("abort test done, kind %0d", k);
    endtask
    task automatic reset_check;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(negedge sys_clk);
        check({converterPowerUp, busy, conversion_complete_flag, converterIrq, 2'b00, sarValue}, 16'h0000);
        check({8'h00, conversionIrqEnable, prescale, channel}, 16'h0000);
        check({6'h00, result}, 16'h0000);
        @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check({converterPowerUp, busy, conversion_complete_flag, converterIrq, 2'b00, sarValue}, 16'h0000);
        $display("reset test done");
    endtask
    initial
    begin
        rst = 1'b1;
        {controlWrite, converterPowerUpIn, statusControlWrite, conversionIrqEnableIn} = 4'h0;
        {pinEnableWrite, resultHighRead, resultLowRead} = 3'h0;
        prescaleIn = 4'h0;
        channelIn = 3'h0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        check({7'h00, converterPowerUp, conversionIrqEnable, prescale, channel}, 16'h0000);
        check({6'h00, result}, 16'h0000);
        for (int ch = 0; ch < 8; ch++)
        begin
            conv(ch[0], ch[2:0], 4'(ch / 7), 1'b0);
            repeat (3) @(negedge sys_clk);
            check(converterIrq, ch[0]);
            strobe((ch % 3 == 2) ? 1 : 3 + ch % 3, 1'b0, 4'h0);
            check({conversion_complete_flag, converterIrq}, 2'b00);
        end
        abort(0, 1'b1);
        abort(2, 1'b1);
        abort(0, 1'b0);
        strobe(1, 1'b1, 4'h2);
        repeat (40) @(negedge sys_clk);
        conv(1'b1, 3'h6, 4'h0, 1'b1);
        reset_check;
        strobe(0, 1'b1, 4'h0);
        strobe(1, 1'b1, 4'h3);
        repeat (40) @(negedge sys_clk);
        reset_check;
        complete_run;
    end
    initial
    begin
        repeat (6000) @(posedge sys_clk);
        err_total++;
        complete_run;
    end
endmodule
